// [logic/tlsm_top.sv]
// Link synchronization monitor with AHB-Lite registers and test-pattern alignment
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: Deserializer lock is watched always; lost lock raises a desync flag beside data.
// RQ2: Desync flag stays high until lock returns, marking every word meanwhile.
// RQ3: Lost lock on a trigger link sets that channel's mask bit.
// RQ4: A frame error also sets the channel's mask bit.
// RQ5: Meanwhile the local controller sends a resync command to the transmitter.
// RQ6: Transmitter sends sync patterns for a fixed interval, then normal data.
// RQ7: Resync completes during data taking without any system reset.
// RQ8: Source sends test patterns only on request from the timing network.
// RQ9: Destination compares test patterns; the marker one arrives in one crossing everywhere.
// RQ10: A marker arriving k crossings late means that channel is k crossings delayed.
// RQ11: Source places the marker in crossing N by its own timing receiver.
// RQ12: Adjustable delay makes the marker land in crossing N locally.
// RQ13: Misalignment is fixed by moving the sync FIFO by matching steps.
// RQ14: New pipeline length or deskew takes effect only through a system reset.
// RQ15: Bunch number counts crossings since the last bunch-zero marker, restarting there.
// RQ16: Masked channel outputs zero; mask clears only with lock and clean frames.
// RQ17: Each sync FIFO step equals one crossing period.
module tlsm_top
	import tlsm_pkg::*;
#(
	parameter int NCH = 4,
	parameter int DW  = 8,
	parameter int BW  = 12,
	parameter int FD  = 16
) (
	input  logic                hclk,              // Bunch-crossing clock, bus clock
	input  logic                hresetn,           // Async reset, active low
	input  logic                ce,                // Clock enable, freezes all state
	input  logic                hsel,              // Slave select
	input  logic [31:0]         haddr,             // Byte address
	input  logic [1:0]          htrans,            // Transfer type
	input  logic                hwrite,            // Write when high
	input  logic [2:0]          hsize,             // Transfer size, word only
	input  logic [31:0]         hwdata,            // Write data
	input  logic                hready,            // Bus ready
	output logic [31:0]         hrdata,            // Read data
	output logic                hreadyout,         // Slave ready
	output logic                hresp,             // Always OKAY
	input  logic [NCH-1:0]      link_lock,         // Deserializer lock per channel
	input  logic [NCH-1:0]      link_frame_err,    // Frame error per channel
	input  logic [NCH*DW-1:0]   link_data,         // Received words, one per crossing
	input  logic                bunch_zero_marker, // Bunch-zero from the timing receiver
	output logic [NCH*DW-1:0]   pipe_data,         // Aligned words into the readout pipe
	output logic [NCH-1:0]      pipe_desync,       // Desync flag with each word
	output logic [NCH*DW-1:0]   trig_word,         // Trigger words, zero while masked
	output logic [NCH-1:0]      trig_mask,         // Channel mask bits
	output logic [NCH-1:0]      resync_cmd,        // Resync command pulse to transmitter
	output logic [BW-1:0]       bunch_num,         // Crossings since bunch-zero
	output logic                irq                // Level interrupt
);
	import tlsm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [2:0]              ctrl_q;
	logic [31:0]             delay_q;     // Programmed steps, not yet live
	logic [31:0]             steps_q;     // Steps in force since last system reset
	logic [31:0]             irq_stat_q;
	logic [31:0]             irq_mask_q;
	logic [BW-1:0]           test_bx_q;
	logic [BW-1:0]           bunch_q;
	logic                    wr_q;
	logic [7:0]              waddr_q;
	logic [31:0]             hrdata_q;
	logic                    hready_q;
	logic                    irq_q;
	logic [NCH-1:0]          lock_q;
	logic [NCH-1:0]          ferr_q;
	logic [NCH-1:0]          mask_q;
	logic [NCH-1:0]          desync_q;
	logic [NCH-1:0]          done_q;
	logic [NCH-1:0]          misal_q;
	logic [NCH-1:0]          cmd_q;
	logic [TLSM_ALIGN_W-1:0] offs_q [NCH];
	logic [DW-1:0]           fifo_out [NCH];
	logic [DW-1:0]           pdat_q [NCH];
	logic [DW-1:0]           tw_q [NCH];
	logic [NCH-1:0]          cmd_w;
	logic [NCH-1:0]          mark_w;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire       addr_ok  = hsel & hready & (htrans == TLSM_HTRANS_NONSEQ);
	wire       rd_ok    = addr_ok & ~hwrite;
	wire [7:0] raddr    = haddr[7:0];
	wire       wr_ctrl  = wr_q & (waddr_q == TLSM_ADDR_CTRL);
	wire       wr_delay = wr_q & (waddr_q == TLSM_ADDR_DELAY);
	wire       wr_imask = wr_q & (waddr_q == TLSM_ADDR_IRQ_MASK);
	wire       wr_tbx   = wr_q & (waddr_q == TLSM_ADDR_TEST_BX);
	wire       rd_clr   = rd_ok & (raddr == TLSM_ADDR_IRQ_STAT);
	wire       sysrst   = wr_ctrl & hwdata[TLSM_CTRL_SYSRST];
	wire       test_en  = ctrl_q[TLSM_CTRL_TEST_EN];
	wire       force_rs = ctrl_q[TLSM_CTRL_FORCE];

	// Status words assembled in named wires
	logic [31:0] status_w;
	logic [31:0] align_w;
	logic [31:0] irq_set_w;
	always_comb begin
		status_w  = '0;
		align_w   = '0;
		irq_set_w = '0;
		for (int c = 0; c < NCH; c++) begin
			status_w[TLSM_STAT_LOCK + c]  = lock_q[c];
			status_w[TLSM_STAT_MASK + c]  = mask_q[c];
			status_w[TLSM_STAT_DONE + c]  = done_q[c];
			status_w[TLSM_STAT_MISAL + c] = misal_q[c];
			align_w[c*TLSM_ALIGN_W +: TLSM_ALIGN_W] = offs_q[c];
			irq_set_w[TLSM_IRQ_DESYNC + c] = lock_q[c] & ~link_lock[c];
			irq_set_w[TLSM_IRQ_FERR + c]   = link_frame_err[c];
			irq_set_w[TLSM_IRQ_MISAL + c]  = mark_w[c] & (bunch_q != test_bx_q);
		end
	end

	// Read mux; unmapped offsets read zero with an OKAY answer
	wire [31:0] rd_mux =
		(raddr == TLSM_ADDR_CTRL)     ? {29'h0000000, ctrl_q} :
		(raddr == TLSM_ADDR_DELAY)    ? delay_q :
		(raddr == TLSM_ADDR_STATUS)   ? status_w :
		(raddr == TLSM_ADDR_IRQ_STAT) ? irq_stat_q :
		(raddr == TLSM_ADDR_IRQ_MASK) ? irq_mask_q :
		(raddr == TLSM_ADDR_ALIGN)    ? align_w :
		(raddr == TLSM_ADDR_TEST_BX)  ? {{(32-BW){1'b0}}, test_bx_q} :
		(raddr == TLSM_ADDR_BUNCH)    ? {{(32-BW){1'b0}}, bunch_q} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, read data captured at the address edge

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q     <= 1'b0;
			waddr_q  <= 8'h00;
			hrdata_q <= 32'h00000000;
			hready_q <= 1'b1;
		end else if (ce) begin
			wr_q     <= addr_ok & hwrite;
			waddr_q  <= raddr;
			hready_q <= 1'b1;
			if (rd_ok) hrdata_q <= rd_mux;
		end
	end

	// Software registers; the system reset bit is a one-shot command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q     <= 3'h0;
			delay_q    <= 32'h00000000;
			irq_mask_q <= 32'h00000000;
			test_bx_q  <= '0;
		end else if (ce) begin
			if (wr_ctrl)  ctrl_q <= {1'b0, hwdata[TLSM_CTRL_FORCE], hwdata[TLSM_CTRL_TEST_EN]};
			if (wr_delay) delay_q <= hwdata;
			if (wr_imask) irq_mask_q <= hwdata;
			if (wr_tbx)   test_bx_q <= hwdata[BW-1:0];
		end
	end

	// New delays go live only on a system reset, never mid-run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			steps_q <= 32'h00000000;
		end else if (ce && sysrst) begin
			steps_q <= delay_q; // RQ14
		end
	end

	// Sticky events; a new event beats the clear-on-read in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= 32'h00000000;
			irq_q      <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= (rd_clr ? 32'h00000000 : irq_stat_q) | irq_set_w;
			irq_q      <= |(((rd_clr ? 32'h00000000 : irq_stat_q) | irq_set_w) & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bunch counter

	// Restarts at each bunch-zero; also cleared by a system reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bunch_q <= '0;
		end else if (ce) begin
			bunch_q <= (bunch_zero_marker || sysrst) ? '0 : bunch_q + 1'b1; // RQ15
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel logic

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		tlsm_link_if lnk ();

		assign lnk.lock     = link_lock[c];
		assign lnk.force_rs = force_rs;
		assign cmd_w[c]     = lnk.cmd;
		// Marker seen in this crossing while the pattern check is armed
		assign mark_w[c]    = test_en & ~done_q[c] & fifo_out[c][TLSM_MARK_BIT];

		tlsm_sync_fifo #(
			.DW    (DW),
			.DEPTH (FD),
			.SW    (TLSM_STEP_W)
		) u_fifo (
			.hclk    (hclk),
			.hresetn (hresetn),
			.ce      (ce),
			.flush   (sysrst),
			.steps   (steps_q[c*TLSM_STEP_W +: TLSM_STEP_W]), // RQ12 RQ13
			.din     (link_data[c*DW +: DW]),
			.dout    (fifo_out[c])
		);

		tlsm_resync_ctrl u_rs (
			.hclk    (hclk),
			.hresetn (hresetn),
			.ce      (ce),
			.lnk     (lnk.ctrl)
		);

		// Link state, flags, mask and output words
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				lock_q[c]   <= 1'b0;
				ferr_q[c]   <= 1'b0;
				desync_q[c] <= 1'b1;
				mask_q[c]   <= 1'b1;
				cmd_q[c]    <= 1'b0;
				pdat_q[c]   <= '0;
				tw_q[c]     <= '0;
			end else if (ce) begin
				lock_q[c]   <= link_lock[c];
				ferr_q[c]   <= link_frame_err[c];
				cmd_q[c]    <= cmd_w[c]; // RQ5
				desync_q[c] <= ~link_lock[c]; // RQ1 RQ2
				pdat_q[c]   <= fifo_out[c];
				if (!link_lock[c] || link_frame_err[c]) begin
					mask_q[c] <= 1'b1; // RQ3 RQ4
				end else begin
					mask_q[c] <= 1'b0; // RQ16
				end
				// Zero the word as soon as the fault shows, not a cycle later
				tw_q[c] <= (!link_lock[c] || link_frame_err[c]) ? '0 : fifo_out[c]; // RQ16
			end
		end

		// Pattern check: offset of the marker from the expected crossing
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				done_q[c]  <= 1'b0;
				misal_q[c] <= 1'b0;
				offs_q[c]  <= '0;
			end else if (ce) begin
				if (!test_en) begin
					done_q[c] <= 1'b0;
				end else if (mark_w[c]) begin
					done_q[c]  <= 1'b1; // RQ9
					misal_q[c] <= (bunch_q != test_bx_q);
					offs_q[c]  <= TLSM_ALIGN_W'(bunch_q - test_bx_q); // RQ10
				end
			end
		end

		assign pipe_data[c*DW +: DW] = pdat_q[c];
		assign trig_word[c*DW +: DW] = tw_q[c];
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops except hresp, which is tied to OKAY

	assign hrdata      = hrdata_q;
	assign hreadyout   = hready_q;
	assign hresp       = TLSM_HRESP_OKAY;
	assign pipe_desync = desync_q;
	assign trig_mask   = mask_q;
	assign resync_cmd  = cmd_q;
	assign bunch_num   = bunch_q;
	assign irq         = irq_q;

endmodule

// [logic/tlsm_pkg.sv]
// Shared constants for the trigger link synchronization monitor
package tlsm_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] TLSM_ADDR_CTRL     = 8'h00;
	localparam logic [7:0] TLSM_ADDR_DELAY    = 8'h04;
	localparam logic [7:0] TLSM_ADDR_STATUS   = 8'h08;
	localparam logic [7:0] TLSM_ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] TLSM_ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] TLSM_ADDR_ALIGN    = 8'h14;
	localparam logic [7:0] TLSM_ADDR_TEST_BX  = 8'h18;
	localparam logic [7:0] TLSM_ADDR_BUNCH    = 8'h1c;

	// Control register bits
	localparam int TLSM_CTRL_TEST_EN  = 0;
	localparam int TLSM_CTRL_FORCE    = 1;
	localparam int TLSM_CTRL_SYSRST   = 2;

	// Channel slots and field layout
	localparam int TLSM_MAX_CH        = 8;
	localparam int TLSM_STEP_W        = 4;
	localparam int TLSM_ALIGN_W       = 4;
	localparam int TLSM_STAT_LOCK     = 0;
	localparam int TLSM_STAT_MASK     = 8;
	localparam int TLSM_STAT_DONE     = 16;
	localparam int TLSM_STAT_MISAL    = 24;
	localparam int TLSM_IRQ_DESYNC    = 0;
	localparam int TLSM_IRQ_FERR      = 8;
	localparam int TLSM_IRQ_MISAL     = 16;
	localparam int TLSM_MARK_BIT      = 0;

	// AHB-Lite encodings
	localparam logic [1:0] TLSM_HTRANS_NONSEQ = 2'b10;
	localparam logic       TLSM_HRESP_OKAY    = 1'b0;

	// Timing: clock period and wait after a resync command
	localparam int TLSM_CLK_NS        = 100;
	localparam int TLSM_RESYNC_NS     = 2000;
	localparam int TLSM_RESYNC_CYC    = (TLSM_RESYNC_NS + TLSM_CLK_NS - 1) / TLSM_CLK_NS;
	localparam int TLSM_HOLD_W        = 8;

	// Resync controller states, one-hot
	typedef enum logic [2:0] {
		TLSM_ST_IDLE = 3'b001,
		TLSM_ST_SEND = 3'b010,
		TLSM_ST_HOLD = 3'b100
	} tlsm_state_t;

endpackage

// [logic/tlsm_link_if.sv]
// Per-channel link status and resync command bundle
`timescale 1ns/100ps
interface tlsm_link_if;
	logic lock;  // Deserializer reports lock
	logic force_rs; // Software forced resync
	logic cmd;   // Resync command pulse to transmitter
	logic busy;  // Resync procedure running

	modport ctrl (input lock, input force_rs, output cmd, output busy);
	modport top  (output lock, output force_rs, input cmd, input busy);
endinterface

// [logic/tlsm_sync_fifo.sv]
// Programmable whole-crossing delay line for one channel
`timescale 1ns/100ps
module tlsm_sync_fifo #(
	parameter int DW    = 8,
	parameter int DEPTH = 16,
	parameter int SW    = 4
) (
	input  logic          hclk,    // Bunch-crossing clock
	input  logic          hresetn, // Async reset, active low
	input  logic          ce,      // Clock enable
	input  logic          flush,   // Soft system reset of the pipe
	input  logic [SW-1:0] steps,   // Extra crossings of delay
	input  logic [DW-1:0] din,     // Word in
	output logic [DW-1:0] dout     // Word out, steps+1 cycles later
);
	logic [DW-1:0] mem [DEPTH];
	logic [SW-1:0] wp_q;
	wire  [SW-1:0] rp = wp_q - steps;

	// Each step is one crossing; zero steps bypasses the array
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q <= '0;
			dout <= '0;
		end else if (ce) begin
			if (flush) begin
				wp_q <= '0;
				dout <= '0;
			end else begin
				wp_q    <= wp_q + 1'b1;
				mem[wp_q] <= din;
				dout    <= (steps == '0) ? din : mem[rp]; // RQ13 RQ17
			end
		end
	end
endmodule

// [logic/tlsm_resync_ctrl.sv]
// Local resync controller for one link
`timescale 1ns/100ps
module tlsm_resync_ctrl
	import tlsm_pkg::*;
(
	input  logic hclk,        // Bunch-crossing clock
	input  logic hresetn,     // Async reset, active low
	input  logic ce,          // Clock enable
	tlsm_link_if.ctrl lnk     // Link status and command
);
	tlsm_state_t             st_q, st_d;
	logic [TLSM_HOLD_W-1:0]  cnt_q;
	localparam logic [TLSM_HOLD_W-1:0] HOLD = TLSM_HOLD_W'(TLSM_RESYNC_CYC - 1);

	assign lnk.cmd  = (st_q == TLSM_ST_SEND);
	assign lnk.busy = (st_q != TLSM_ST_IDLE);

	// Lost lock starts a resync while data taking goes on; no reset needed
	always_comb begin
		st_d = st_q;
		case (st_q)
			TLSM_ST_IDLE: if (!lnk.lock || lnk.force_rs) st_d = TLSM_ST_SEND; // RQ5 RQ7
			TLSM_ST_SEND: st_d = TLSM_ST_HOLD;
			TLSM_ST_HOLD: if (cnt_q == '0) st_d = TLSM_ST_IDLE;
			default:      st_d = TLSM_ST_IDLE;
		endcase
	end

	// Wait out the far end's pattern interval before asking again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q  <= TLSM_ST_IDLE;
			cnt_q <= '0;
		end else if (ce) begin
			st_q  <= st_d;
			cnt_q <= (st_q == TLSM_ST_SEND) ? HOLD : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q); // RQ6
		end
	end
endmodule

// [tb/tlsm_top_checker.sv]
// Port assertions for the link synchronization monitor
`timescale 1ns/100ps
module tlsm_top_checker #(
	parameter int NCH = 4,
	parameter int DW  = 8,
	parameter int BW  = 12
) (
	input logic              hclk,              // Crossing clock
	input logic              hresetn,           // Reset, active low
	input logic [NCH-1:0]    link_lock,         // Lock in
	input logic [NCH-1:0]    link_frame_err,    // Frame error in
	input logic              bunch_zero_marker, // Bunch zero in
	input logic [NCH-1:0]    pipe_desync,       // Desync flags
	input logic [NCH*DW-1:0] trig_word,         // Trigger words
	input logic [NCH-1:0]    trig_mask,         // Mask bits
	input logic [NCH-1:0]    resync_cmd,        // Resync pulses
	input logic [BW-1:0]     bunch_num          // Bunch count
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       up_q;   // Outputs follow inputs from here on
	logic [5:0] wait_q; // Crossings unlocked with no command
	// Helper counters; the first edge after reset still shows reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_q   <= 1'b0;
			wait_q <= 6'h00;
		end else begin
			up_q   <= 1'b1;
			wait_q <= (link_lock[0] || resync_cmd[0]) ? 6'h00 : wait_q + 6'h01;
		end
	end
	sequence lock_back;
		$rose(link_lock[0]) && !link_frame_err[0];
	endsequence
	sequence cmd_then_quiet;
		resync_cmd[0] ##1 !resync_cmd[0] [*8];
	endsequence
	AST_DESYNC_FLAG: assert property (up_q |-> pipe_desync == ~$past(link_lock))
		else $error("desync flag wrong");
	AST_RECOVER: assert property ((up_q and lock_back) |=> !pipe_desync[0] && !trig_mask[0])
		else $error("flag or mask stuck");
	AST_MASK_CAUSE: assert property (up_q |-> trig_mask == (~$past(link_lock) | $past(link_frame_err)))
		else $error("mask wrong");
	AST_MASK_ZERO: assert property (trig_mask[0] |-> trig_word[DW-1:0] == '0)
		else $error("masked word not zero");
	AST_CMD_CAUSE: assert property (resync_cmd[0] |-> !$past(link_lock[0], 2))
		else $error("command without lock loss");
	AST_CMD_SPACING: assert property (resync_cmd[0] |-> cmd_then_quiet)
		else $error("commands too close");
	AST_CMD_RETRY: assert property (wait_q < 6'd25)
		else $error("no resync command");
	AST_BUNCH_RESTART: assert property (bunch_zero_marker |=> bunch_num == '0)
		else $error("bunch count not restarted");
endmodule
bind tlsm_top tlsm_top_checker #(.NCH(NCH), .DW(DW), .BW(BW)) tlsm_top_checker_inst (.hclk(hclk),
	.hresetn(hresetn), .link_lock(link_lock), .link_frame_err(link_frame_err),
	.bunch_zero_marker(bunch_zero_marker), .pipe_desync(pipe_desync), .trig_word(trig_word),
	.trig_mask(trig_mask), .resync_cmd(resync_cmd), .bunch_num(bunch_num));

// [tb/tlsm_fe_model.sv]
// Behavioural front-end serializer feeding the monitor's links
`timescale 1ns/100ps
module tlsm_fe_model #(
	parameter int NCH      = 4,
	parameter int DW       = 8,
	parameter int SYNC_CYC = 12
) (
	input  logic              hclk,       // Crossing clock
	input  logic              hresetn,    // Reset, active low
	input  logic [NCH-1:0]    resync_cmd, // Resync command per link
	input  logic [NCH-1:0]    brk,        // Bench knocks a link out of lock
	input  logic              test_req,   // Broadcast test request
	input  logic [4*NCH-1:0]  lag,        // Extra cable crossings per link
	input  logic [31:0]       rnd,        // Fresh random bits each crossing
	output logic [NCH-1:0]    link_lock,  // Lock seen at reception
	output logic [NCH*DW-1:0] link_data   // Words after the cable
);
	logic [5:0] tq_q; // Crossings since the test request
	// One shared count, as the request reaches every source at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tq_q <= 6'h3f;
		end else begin
			tq_q <= test_req ? 6'h00 : (tq_q == 6'h3f ? tq_q : tq_q + 6'h01);
		end
	end
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [5:0] sc_q; // Sync crossings left
		logic       mark; // Marker crossing, late by the cable lag
		assign mark = (tq_q == 6'd2 + {2'b00, lag[4*c +: 4]});
		// Lock held low for a fixed run of SYNC_CYC crossings, so garbage rather than sync words, then lock and plain data again
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				sc_q         <= 6'h00;
				link_lock[c] <= 1'b0;
			end else if (brk[c]) begin
				link_lock[c] <= 1'b0;
			end else if (resync_cmd[c]) begin
				sc_q <= 6'(SYNC_CYC);
			end else if (sc_q != 6'h00) begin
				sc_q         <= sc_q - 6'h01;
				link_lock[c] <= (sc_q == 6'h01);
			end
		end
		// Unlocked links carry changing garbage; on locked links only the test pattern sets bit 0
		assign link_data[DW*c +: DW] = !link_lock[c] ? ~rnd[DW*c +: DW] :
			(sc_q != 6'h00) ? {{(DW-1){1'b1}}, 1'b0} : {rnd[DW*c+1 +: DW-1], mark};
	end
endmodule

// [tb/trigger_link_sync_monitor_test.sv]
// Self-checking bench for the link synchronization monitor
`timescale 1ns/100ps
module trigger_link_sync_monitor_test;
	import tlsm_pkg::*;
	localparam int NCH = 4;
	localparam int DW  = 8;
	logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, bzm, test_req;
	logic [1:0]        htrans;
	logic [31:0]       haddr, hwdata, hrdata, rnd;
	logic [NCH-1:0]    link_lock, link_frame_err, pipe_desync, trig_mask, resync_cmd, brk, lk_p, fe_p;
	logic [NCH*DW-1:0] link_data, pipe_data, trig_word;
	logic [11:0]       bunch_num;
	logic [15:0]       lag, a0, a1, a2;
	int                seed = 32'hef8ffc37;
	int                fails, checks, cyc, live, nfl, sfl;
	logic [NCH*DW-1:0] pq[$]; // Received words, newest first
	int                lg[NCH], st[NCH];
	tlsm_top #(.NCH(NCH), .DW(DW)) tlsm_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_lock(link_lock),
		.link_frame_err(link_frame_err), .link_data(link_data), .bunch_zero_marker(bzm), .pipe_data(pipe_data),
		.pipe_desync(pipe_desync), .trig_word(trig_word), .trig_mask(trig_mask), .resync_cmd(resync_cmd),
		.bunch_num(bunch_num), .irq(irq));
	tlsm_fe_model #(.NCH(NCH), .DW(DW)) tlsm_fe_model_inst (.hclk(hclk), .hresetn(hresetn),
		.resync_cmd(resync_cmd), .brk(brk), .test_req(test_req), .lag(lag), .rnd(rnd),
		.link_lock(link_lock), .link_data(link_data));
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Single AHB-Lite transfer; waits on hready, never on a fixed count
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		htrans <= TLSM_HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic wait_lock();
		for (int i = 0; i < 200 && link_lock !== '1; i++)
			@(posedge hclk);
		repeat (2) @(posedge hclk);
	endtask
	task automatic hit(input logic [NCH-1:0] b, input logic [NCH-1:0] f);
		brk            <= b;
		link_frame_err <= f;
		@(posedge hclk);
		brk            <= '0;
		link_frame_err <= '0;
		repeat (3) @(posedge hclk);
	endtask
	// Test pattern run; returns the measured offsets
	task automatic run_test(output logic [15:0] al);
		logic [31:0] r;
		wr(TLSM_ADDR_CTRL, 32'h0);
		wr(TLSM_ADDR_CTRL, 32'h1);
		test_req <= 1'b1;
		@(posedge hclk);
		test_req <= 1'b0;
		repeat (40) @(posedge hclk);
		bus(1'b0, TLSM_ADDR_STATUS, 32'h0, r);
		chk(r & 32'h000f000f, 32'h000f000f);
		bus(1'b0, TLSM_ADDR_ALIGN, 32'h0, r);
		al = r[15:0];
	endtask
	// Channel offsets relative to channel 0 follow cable lag plus the live steps
	task automatic cmp_al(input logic [15:0] al);
		for (int c = 0; c < NCH; c++)
			chk({28'h0, al[4*c +: 4] - al[3:0]}, 32'((lg[c] + st[c] - lg[0] - st[0]) & 15));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// Reference model: flag and mask follow the link state one crossing later
	always @(posedge hclk) begin
		if (live >= 2) begin
			chk({28'h0, pipe_desync}, {28'h0, ~lk_p});
			chk({28'h0, trig_mask}, {28'h0, ~lk_p | fe_p});
			for (int c = 0; c < NCH; c++)
				if (trig_mask[c])
					chk({24'h0, trig_word[DW*c +: DW]}, 32'h0);
			// Pipe words trail the link by two crossings plus the live steps
			if (sfl == nfl && pq.size() > 8)
				for (int c = 0; c < NCH; c++)
					chk({24'h0, pipe_data[DW*c +: DW]}, {24'h0, pq[1 + st[c]][DW*c +: DW]});
		end
		// A flush leaves stale words in the pipe, so history restarts there
		if (sfl != nfl)
			pq.delete();
		sfl <= nfl;
		pq.push_front(link_data);
		if (pq.size() > 9)
			void'(pq.pop_back());
		lk_p <= link_lock;
		fe_p <= link_frame_err;
		rnd  <= $random(seed);
		live <= hresetn ? live + 1 : 0;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		logic [31:0] dv;
		foreach (lg[c]) lg[c] = $random(seed) & 3;
		{hresetn, hwrite, bzm, test_req, htrans, haddr, hwdata, link_frame_err, brk, lag} = '0;
		hsel = 1'b1;
		st = '{default: 0};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(TLSM_ADDR_CTRL, 32'h0);
		rd(8'h40, 32'h0);
		wait_lock();
		rd(TLSM_ADDR_STATUS, 32'h0000000f);
		bzm <= 1'b1;
		@(posedge hclk);
		bzm <= 1'b0;
		// Interrupt raised, read and cleared, then masked
		wr(TLSM_ADDR_IRQ_MASK, 32'h0);
		rd(TLSM_ADDR_IRQ_STAT, 32'h0);
		wr(TLSM_ADDR_IRQ_MASK, 32'h1);
		hit(4'h1, 4'h0);
		chk({31'h0, irq}, 32'h1);
		rd(TLSM_ADDR_IRQ_STAT, 32'h1);
		wait_lock();
		chk({31'h0, irq}, 32'h0);
		wr(TLSM_ADDR_IRQ_MASK, 32'h0);
		hit(4'h2, 4'h4);
		chk({31'h0, irq}, 32'h0);
		rd(TLSM_ADDR_IRQ_STAT, 32'h00000402);
		wait_lock();
		// Alignment: measure, program steps, apply only after a system reset
		for (int c = 0; c < NCH; c++)
			lag[4*c +: 4] <= 4'(lg[c]);
		run_test(a0);
		cmp_al(a0);
		for (int c = 0; c < NCH; c++)
			dv[4*c +: 4] = 4'(3 - lg[c]);
		wr(TLSM_ADDR_DELAY, {16'h0, dv[15:0]});
		run_test(a1);
		cmp_al(a1);
		wr(TLSM_ADDR_CTRL, 32'h4);
		nfl++;
		for (int c = 0; c < NCH; c++)
			st[c] = 3 - lg[c];
		run_test(a2);
		cmp_al(a2);
		chk({16'h0, a2 ^ {4{a2[3:0]}}}, 32'h0);
		test_done();
	end
endmodule
